/* File: shared/gsc_pkg.sv */
// Package for the gated sixteen-bit counter: field layouts, widths and reset values.
// Assumes a single 100 MHz system clock and a synchronous active-high reset.
package gsc_pkg;

  // ----------------------------------------
  // Widths and reset values
  // ----------------------------------------
  localparam int unsigned COUNT_W = 16;
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned PRESC_W = 3;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] COUNT_MAX = 16'hffff;
  localparam logic [2:0] PRESC_RESET = 3'h0;
  localparam logic [2:0] PRESC_ONE = 3'h1;

  // ----------------------------------------
  // Prescale selections
  // ----------------------------------------
  typedef enum logic [1:0] {
    GSC_DIV1 = 2'b00,
    GSC_DIV2 = 2'b01,
    GSC_DIV4 = 2'b10,
    GSC_DIV8 = 2'b11
  } gsc_presc_e;

  localparam logic [2:0] PRESC_MASK1 = 3'h0;
  localparam logic [2:0] PRESC_MASK2 = 3'h1;
  localparam logic [2:0] PRESC_MASK4 = 3'h3;
  localparam logic [2:0] PRESC_MASK8 = 3'h7;

  // ----------------------------------------
  // Grouped signals
  // ----------------------------------------
  typedef struct packed {
    logic run;
    logic secondary_osc_enable;
    logic sync_disable;
    gsc_presc_e prescale_select;
  } gsc_ctrl_s;

  typedef struct packed {
    logic gate_enable_bit;
    logic gate_polarity;
    logic [1:0] gate_select;
  } gsc_gate_s;

  typedef struct packed {
    logic wr_high;
    logic wr_low;
    logic [7:0] wdata;
    logic clr_flag;
  } gsc_wr_s;

  typedef struct packed {
    logic [15:0] count;
    logic [2:0] presc;
    logic clk_sync_r;
    logic clk_prev;
    logic [7:0] high_latch;
    logic overflow_flag;
    logic osc_run;
    logic sync_prev;
  } gsc_state_s;

endpackage

/* File: logic/gsc_counter.sv */
// Gated sixteen-bit counter with prescaler, secondary oscillator gate and overflow flag.
// Assumes all inputs are synchronous to clk_i; the count clock is sampled as a level.
// Notes on behaviour
// - Prescaler divides count clock by 1,2,4,8.
// - Count byte writes clear hidden prescale counter.
// - Secondary oscillator runs only when enabled.
// - Enabled oscillator keeps running during sleep.
// - Sync disable skips clock input synchroniser.
// - Asynchronous external mode counts in sleep, wakes.
// - Mode switch may drop increment, never adds one.
// - Reading either count byte returns valid value.
// - Counter counts freely unless gate enabled.
// - Gate taken from one of several sources.
// - Polarity bit selects counting gate level.
// - Rising clock edge increments while gate permits.
`timescale 1ns/1ps
module gsc_counter (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Control
  input wire gsc_pkg::gsc_ctrl_s ctrl_i,
  input wire gsc_pkg::gsc_gate_s gate_cfg_i,
  input wire gsc_pkg::gsc_wr_s wr_i,
  input wire logic sleep_i,
  input wire logic ext_clock_sel_i,
  input wire logic rd_low_i,
  // Pins and sources
  input wire logic count_clock_i,
  input wire logic crystal_in_pin_i,
  input wire logic [3:0] gate_input_i,
  // Results
  output logic crystal_out_pin_o,
  output logic crystal_out_oe_o,
  output logic [7:0] count_low_byte_o,
  output logic [7:0] count_high_byte_o,
  output logic overflow_flag_o,
  output logic wake_o
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  gsc_pkg::gsc_state_s st_r;
  gsc_pkg::gsc_state_s st_nxt;
  logic src_clk;
  logic clk_level;
  logic clk_rise;
  logic gate_lvl;
  logic gate_ok;
  logic tick;
  logic [2:0] presc_mask;
  logic cnt_inc;
  logic clock_alive;

  // ----------------------------------------
  // Combinational next state
  // ----------------------------------------
  always_comb begin
    st_nxt = st_r;
    // Oscillator amplifier only runs when enabled; sleep does not stop it.
    st_nxt.osc_run = ctrl_i.secondary_osc_enable;
    src_clk = ext_clock_sel_i ? (st_r.osc_run & crystal_in_pin_i) : count_clock_i;
    st_nxt.clk_sync_r = src_clk;
    // Bypassing the synchroniser trades a cycle of latency for metastability risk.
    clk_level = ctrl_i.sync_disable ? src_clk : st_r.clk_sync_r;
    st_nxt.clk_prev = clk_level;
    st_nxt.sync_prev = ctrl_i.sync_disable;
    clk_rise = clk_level & ~st_r.clk_prev;
    // In sleep only an unsynchronised external clock keeps the counter alive.
    clock_alive = ~sleep_i | (ctrl_i.sync_disable & ext_clock_sel_i);
    gate_lvl = gate_input_i[gate_cfg_i.gate_select];
    gate_ok = ~gate_cfg_i.gate_enable_bit
      | (gate_lvl == gate_cfg_i.gate_polarity);
    tick = ctrl_i.run & clock_alive & gate_ok & clk_rise;
    unique case (ctrl_i.prescale_select)
      gsc_pkg::GSC_DIV1: presc_mask = gsc_pkg::PRESC_MASK1;
      gsc_pkg::GSC_DIV2: presc_mask = gsc_pkg::PRESC_MASK2;
      gsc_pkg::GSC_DIV4: presc_mask = gsc_pkg::PRESC_MASK4;
      gsc_pkg::GSC_DIV8: presc_mask = gsc_pkg::PRESC_MASK8;
    endcase
    cnt_inc = tick & ((st_r.presc & presc_mask) == presc_mask);
    if (tick) begin
      st_nxt.presc = st_r.presc + gsc_pkg::PRESC_ONE;
    end
    if (cnt_inc) begin
      st_nxt.count = st_r.count + 16'h0001;
    end
    // A write wins over a coincident increment in its own byte only, and both writes clear the prescaler.
    if (wr_i.wr_low) begin
      st_nxt.count[7:0] = wr_i.wdata;
      st_nxt.presc = gsc_pkg::PRESC_RESET;
    end
    if (wr_i.wr_high) begin
      st_nxt.count[15:8] = wr_i.wdata;
      st_nxt.presc = gsc_pkg::PRESC_RESET;
    end
    // High byte is latched on a low-byte read so the pair stays coherent.
    if (rd_low_i) begin
      st_nxt.high_latch = st_r.count[15:8];
    end
    if (wr_i.clr_flag) begin
      st_nxt.overflow_flag = 1'b0;
    end
    // Set beats clear so a rollover in the clearing cycle is kept.
    if (cnt_inc && st_r.count == gsc_pkg::COUNT_MAX && !wr_i.wr_low && !wr_i.wr_high) begin
      st_nxt.overflow_flag = 1'b1;
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign crystal_out_pin_o = ~crystal_in_pin_i & st_r.osc_run;
  assign crystal_out_oe_o = st_r.osc_run;
  assign count_low_byte_o = st_r.count[7:0];
  assign count_high_byte_o = rd_low_i ? st_r.count[15:8] : st_r.high_latch;
  assign overflow_flag_o = st_r.overflow_flag;
  assign wake_o = st_r.overflow_flag & sleep_i;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  logic [2:0] div_cnt;
  always_ff @(posedge clk_i) begin
    if (reset_i || wr_i.wr_low || wr_i.wr_high) begin
      div_cnt <= 3'h0;
    end else if (tick) begin
      div_cnt <= div_cnt + 3'h1;
    end
  end

  presc_div8_a: assert property (@(posedge clk_i) disable iff (reset_i)
    (tick && ctrl_i.prescale_select == gsc_pkg::GSC_DIV8 && div_cnt != 3'h7
     && !wr_i.wr_low && !wr_i.wr_high) |=> $stable(st_r.count))
    else $error("Count moved before eighth tick.");
  presc_div1_a: assert property (@(posedge clk_i) disable iff (reset_i)
    (tick && ctrl_i.prescale_select == gsc_pkg::GSC_DIV1
     && !wr_i.wr_low && !wr_i.wr_high) |=> st_r.count == $past(st_r.count) + 16'h0001)
    else $error("Divide by one missed increment.");
  presc_clear_a: assert property (@(posedge clk_i) disable iff (reset_i)
    (wr_i.wr_low || wr_i.wr_high) |=> st_r.presc == gsc_pkg::PRESC_RESET)
    else $error("Prescaler not cleared by write.");
  osc_enable_a: assert property (@(posedge clk_i) disable iff (reset_i)
    !ctrl_i.secondary_osc_enable |=> !crystal_out_oe_o)
    else $error("Oscillator drives while disabled.");
  osc_sleep_a: assert property (@(posedge clk_i) disable iff (reset_i)
    (ctrl_i.secondary_osc_enable && sleep_i) |=> st_r.osc_run)
    else $error("Oscillator stopped in sleep.");
  sleep_hold_a: assert property (@(posedge clk_i) disable iff (reset_i)
    (sleep_i && !ctrl_i.sync_disable && !wr_i.wr_low && !wr_i.wr_high)
    |=> $stable(st_r.count))
    else $error("Synchronous count ran in sleep.");
  gate_hold_a: assert property (@(posedge clk_i) disable iff (reset_i)
    (gate_cfg_i.gate_enable_bit && gate_lvl != gate_cfg_i.gate_polarity
     && !wr_i.wr_low && !wr_i.wr_high) |=> $stable(st_r.count))
    else $error("Count moved while gate blocked.");
  no_edge_a: assert property (@(posedge clk_i) disable iff (reset_i)
    (!clk_rise && !wr_i.wr_low && !wr_i.wr_high) |=> $stable(st_r.count))
    else $error("Count moved without clock edge.");
  ovf_set_a: assert property (@(posedge clk_i) disable iff (reset_i)
    (cnt_inc && st_r.count == gsc_pkg::COUNT_MAX && !wr_i.wr_low && !wr_i.wr_high)
    |=> overflow_flag_o ##1 (overflow_flag_o || $past(wr_i.clr_flag)))
    else $error("Rollover did not set flag.");
  read_pair_a: assert property (@(posedge clk_i) disable iff (reset_i)
    rd_low_i |=> st_r.high_latch == $past(st_r.count[15:8]))
    else $error("High byte not latched on read.");

  // ----------------------------------------
  // Checks on prescaler and writes
  // ----------------------------------------
  logic no_wr;
  assign no_wr = ~wr_i.wr_low & ~wr_i.wr_high;

  presc_div2_a: assert property (@(posedge clk_i) disable iff (reset_i)
    (tick && ctrl_i.prescale_select == gsc_pkg::GSC_DIV2 && !div_cnt[0] && no_wr)
    |=> $stable(st_r.count))
    else $error("Count moved before second tick.");
  presc_div4_a: assert property (@(posedge clk_i) disable iff (reset_i)
    (tick && ctrl_i.prescale_select == gsc_pkg::GSC_DIV4 && div_cnt[1:0] != 2'h3 && no_wr)
    |=> $stable(st_r.count))
    else $error("Count moved before fourth tick.");
  presc_hit_a: assert property (@(posedge clk_i) disable iff (reset_i)
    (tick && ctrl_i.prescale_select == gsc_pkg::GSC_DIV8 && div_cnt == 3'h7 && no_wr)
    |=> st_r.count == $past(st_r.count) + 16'h0001)
    else $error("Eighth tick did not increment.");
  presc_idle_a: assert property (@(posedge clk_i) disable iff (reset_i)
    (!tick && no_wr) |=> $stable(st_r.presc))
    else $error("Prescaler moved without a tick.");
  write_low_a: assert property (@(posedge clk_i) disable iff (reset_i)
    wr_i.wr_low |=> st_r.count[7:0] == $past(wr_i.wdata))
    else $error("Low byte write lost.");
  write_high_a: assert property (@(posedge clk_i) disable iff (reset_i)
    wr_i.wr_high |=> st_r.count[15:8] == $past(wr_i.wdata))
    else $error("High byte write lost.");

  // ----------------------------------------
  // Checks on mode, sleep and oscillator
  // ----------------------------------------
  async_edge_a: assert property (@(posedge clk_i) disable iff (reset_i)
    (ctrl_i.sync_disable && $past(ctrl_i.sync_disable) && $rose(src_clk))
    |-> clk_rise)
    else $error("Unsynchronised edge was delayed.");
  sync_edge_a: assert property (@(posedge clk_i) disable iff (reset_i)
    (!ctrl_i.sync_disable && !$past(ctrl_i.sync_disable) && $rose(src_clk))
    |=> (ctrl_i.sync_disable || clk_rise))
    else $error("Synchronised edge not seen one cycle later.");
  mode_switch_a: assert property (@(posedge clk_i) disable iff (reset_i)
    (st_r.sync_prev != ctrl_i.sync_disable && no_wr)
    |=> (st_r.count == $past(st_r.count) || st_r.count == $past(st_r.count) + 16'h0001))
    else $error("Mode switch moved count by more than one.");
  osc_run_a: assert property (@(posedge clk_i) disable iff (reset_i)
    ctrl_i.secondary_osc_enable |=> crystal_out_oe_o)
    else $error("Oscillator did not start when enabled.");
  osc_quiet_a: assert property (@(posedge clk_i) disable iff (reset_i)
    !crystal_out_oe_o |-> !crystal_out_pin_o)
    else $error("Amplifier output active while stopped.");
  xtal_idle_a: assert property (@(posedge clk_i) disable iff (reset_i)
    (ext_clock_sel_i && ctrl_i.sync_disable && !st_r.osc_run) |-> !clk_rise)
    else $error("Stopped oscillator produced a count edge.");
  async_sleep_a: assert property (@(posedge clk_i) disable iff (reset_i)
    (sleep_i && ctrl_i.sync_disable && ext_clock_sel_i && ctrl_i.run && gate_ok && clk_rise
     && ctrl_i.prescale_select == gsc_pkg::GSC_DIV1 && no_wr)
    |=> st_r.count == $past(st_r.count) + 16'h0001)
    else $error("Asynchronous count stalled in sleep.");
  sleep_source_a: assert property (@(posedge clk_i) disable iff (reset_i)
    (sleep_i && !ext_clock_sel_i && no_wr)
    |=> $stable(st_r.count))
    else $error("Count clock ran in sleep.");
  wake_set_a: assert property (@(posedge clk_i) disable iff (reset_i)
    (sleep_i && cnt_inc && st_r.count == gsc_pkg::COUNT_MAX && no_wr)
    |=> (wake_o || !sleep_i))
    else $error("Rollover in sleep raised no wake.");
  wake_awake_a: assert property (@(posedge clk_i) disable iff (reset_i)
    !sleep_i |-> !wake_o)
    else $error("Wake raised while awake.");

  // ----------------------------------------
  // Checks on the gate
  // ----------------------------------------
  free_run_a: assert property (@(posedge clk_i) disable iff (reset_i)
    (!gate_cfg_i.gate_enable_bit && ctrl_i.run && clock_alive && clk_rise
     && ctrl_i.prescale_select == gsc_pkg::GSC_DIV1 && no_wr)
    |=> st_r.count == $past(st_r.count) + 16'h0001)
    else $error("Free-running count ignored an edge.");

  // One check per source, so a wrong select cannot hide behind another source.
  for (genvar gi = 0; gi < $bits(gate_input_i); gi++) begin : g_gate_src
    gate_src_a: assert property (@(posedge clk_i) disable iff (reset_i)
      (gate_cfg_i.gate_enable_bit && gate_cfg_i.gate_select == 2'(gi)
       && gate_input_i[gi] == gate_cfg_i.gate_polarity && ctrl_i.run && clock_alive
       && clk_rise && ctrl_i.prescale_select == gsc_pkg::GSC_DIV1 && no_wr)
      |=> st_r.count == $past(st_r.count) + 16'h0001)
      else $error("Selected gate source did not pass an edge.");
  end

  // ----------------------------------------
  // Checks on flag, read latch and reset
  // ----------------------------------------
  flag_hold_a: assert property (@(posedge clk_i) disable iff (reset_i)
    (overflow_flag_o && !wr_i.clr_flag) |=> overflow_flag_o)
    else $error("Overflow flag dropped without clear.");
  flag_clear_a: assert property (@(posedge clk_i) disable iff (reset_i)
    (wr_i.clr_flag && !(cnt_inc && st_r.count == gsc_pkg::COUNT_MAX && no_wr))
    |=> !overflow_flag_o)
    else $error("Clear left the flag set.");
  flag_cause_a: assert property (@(posedge clk_i) disable iff (reset_i)
    $rose(overflow_flag_o)
    |-> ($past(st_r.count) == gsc_pkg::COUNT_MAX && st_r.count == gsc_pkg::COUNT_RESET))
    else $error("Flag set without rollover.");
  latch_hold_a: assert property (@(posedge clk_i) disable iff (reset_i)
    !rd_low_i |=> $stable(st_r.high_latch))
    else $error("High byte latch changed without read.");
  high_mux_a: assert property (@(posedge clk_i) disable iff (reset_i)
    !rd_low_i |-> count_high_byte_o == st_r.high_latch)
    else $error("High byte output not from latch.");
  reset_clear_a: assert property (@(posedge clk_i)
    reset_i |=> (st_r.count == gsc_pkg::COUNT_RESET && !overflow_flag_o && !crystal_out_oe_o))
    else $error("Reset left state behind.");

  // ----------------------------------------
  // Cover points
  // ----------------------------------------

  rollover_c: cover property (@(posedge clk_i) disable iff (reset_i)
    cnt_inc && st_r.count == gsc_pkg::COUNT_MAX);
  gated_c: cover property (@(posedge clk_i) disable iff (reset_i)
    gate_cfg_i.gate_enable_bit && clk_rise && !gate_ok);
  async_sleep_c: cover property (@(posedge clk_i) disable iff (reset_i)
    sleep_i && cnt_inc);
  div8_c: cover property (@(posedge clk_i) disable iff (reset_i)
    cnt_inc && ctrl_i.prescale_select == gsc_pkg::GSC_DIV8);
  mode_switch_c: cover property (@(posedge clk_i) disable iff (reset_i)
    st_r.sync_prev != ctrl_i.sync_disable && ctrl_i.run);

endmodule

/* File: dv/gsc_far_model.sv */
// Far side of the counter: count clock source and a crystal.
// Assumes clk_i is the bench clock; sources change on its falling edge.
`timescale 1ns/1ps
module gsc_far_model (
  // Clock
  input wire logic clk_i,
  // Crystal amplifier
  input wire logic xtal_oe_i,
  // Sources
  output logic count_clock_o,
  output logic crystal_in_o
);
  logic [1:0] div_r = 2'h0;
  initial count_clock_o = 1'b0;
  initial crystal_in_o = 1'b0;
  // The crystal swings only while the amplifier drives it, else it rests low.
  always @(negedge clk_i) begin
    div_r <= xtal_oe_i ? div_r + 2'h1 : 2'h0;
    crystal_in_o <= xtal_oe_i & div_r[1];
  end
  // Direct level control, for an edge that must line up with a bench action.
  task automatic drive(input logic v);
    count_clock_o = v;
  endtask
  // Slow clock, three system cycles per half period, so every edge is seen.
  task automatic burst(input int n);
    repeat (n) begin
      repeat (3) @(negedge clk_i);
      count_clock_o = 1'b1;
      repeat (3) @(negedge clk_i);
      count_clock_o = 1'b0;
    end
  endtask
endmodule

/* File: dv/gsc_counter_test.sv */
// Self-checking bench for the gated counter.
// Assumes gsc_far_model supplies the count clock and the crystal.
`timescale 1ns/1ps
module gsc_counter_test;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  gsc_pkg::gsc_ctrl_s ctrl;
  gsc_pkg::gsc_gate_s gcfg;
  gsc_pkg::gsc_wr_s wr;
  logic sleep;
  logic ext_sel;
  logic rd_low;
  logic [3:0] gate_in;
  logic [15:0] rd_val;
  logic cclk, xin, xout, xoe, flag, wake;
  logic [7:0] lo, hi;
  int err_total = 0;
  int num_checks = 0;
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  gsc_far_model u_far (.clk_i(clk_i), .xtal_oe_i(xoe), .count_clock_o(cclk),
    .crystal_in_o(xin));
  gsc_counter u_dut (.clk_i(clk_i), .reset_i(reset_i), .ctrl_i(ctrl), .gate_cfg_i(gcfg),
    .wr_i(wr), .sleep_i(sleep), .ext_clock_sel_i(ext_sel), .rd_low_i(rd_low),
    .count_clock_i(cclk), .crystal_in_pin_i(xin), .gate_input_i(gate_in),
    .crystal_out_pin_o(xout), .crystal_out_oe_o(xoe), .count_low_byte_o(lo),
    .count_high_byte_o(hi), .overflow_flag_o(flag), .wake_o(wake));
  // ----------------------------------------
  // Access tasks
  // ----------------------------------------
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr_byte(input logic high, input logic [7:0] d);
    @(negedge clk_i);
    wr.wr_high = high;
    wr.wr_low = !high;
    wr.wdata = d;
    @(negedge clk_i);
    wr = '0;
  endtask
  // Writes go in while the count clock is quiet, so no increment contends.
  task automatic load(input logic [15:0] v);
    wr_byte(1'b1, v[15:8]);
    wr_byte(1'b0, v[7:0]);
  endtask
  task automatic clear_flag();
    @(negedge clk_i);
    wr.clr_flag = 1'b1;
    @(negedge clk_i);
    wr.clr_flag = 1'b0;
  endtask
  task automatic read_count(output logic [15:0] v);
    @(negedge clk_i);
    rd_low = 1'b1;
    #1 v = {hi, lo};
    @(negedge clk_i);
    rd_low = 1'b0;
  endtask
  task automatic expect_count(input string what, input logic [15:0] e);
    logic [15:0] v;
    read_count(v);
    check(what, v, e);
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    #300000;
    err_total++;
    finish_test();
  end
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    ctrl = '0;
    gcfg = '0;
    wr = '0;
    sleep = 1'b0;
    ext_sel = 1'b0;
    rd_low = 1'b0;
    gate_in = 4'h0;
    repeat (16) @(negedge clk_i);
    reset_i = 1'b0;
    expect_count("reset count", 16'h0000);
    check("reset flag", 16'(flag), 16'h0000);
    check("osc idle", 16'(xoe), 16'h0000);
    $display("test reset done");
    for (int s = 0; s < 4; s++) begin
      load(16'h0000);
      ctrl.prescale_select = gsc_pkg::gsc_presc_e'(s);
      ctrl.run = 1'b1;
      u_far.burst(8);
      expect_count("prescaled count", 16'(8 >> s));
    end
    u_far.burst(7);
    wr_byte(1'b0, 8'h05);
    u_far.burst(7);
    expect_count("prescaler cleared", 16'h0005);
    u_far.burst(1);
    expect_count("prescaler wrap", 16'h0006);
    $display("test prescaler done");
    ctrl.prescale_select = gsc_pkg::GSC_DIV1;
    gcfg.gate_enable_bit = 1'b1;
    for (int g = 0; g < 8; g++) begin
      load(16'h0100);
      gcfg.gate_select = g[1:0];
      gcfg.gate_polarity = g[2];
      gate_in = {4{!g[2]}};
      u_far.burst(2);
      gate_in[g[1:0]] = g[2];
      u_far.burst(3);
      expect_count("gated count", 16'h0103);
    end
    gcfg.gate_enable_bit = 1'b0;
    gate_in = 4'h0;
    load(16'h0000);
    u_far.burst(2);
    expect_count("free count", 16'h0002);
    load(16'h00ff);
    ctrl.sync_disable = 1'b1;
    @(negedge clk_i);
    u_far.drive(1'b1);
    rd_low = 1'b1;
    #1 rd_val[7:0] = lo;
    @(negedge clk_i);
    rd_low = 1'b0;
    u_far.drive(1'b0);
    #1 rd_val[15:8] = hi;
    check("pair across carry", rd_val, 16'h00ff);
    expect_count("async count", 16'h0100);
    load(16'h0000);
    u_far.burst(2);
    ctrl.sync_disable = 1'b0;
    u_far.burst(2);
    ctrl.sync_disable = 1'b1;
    u_far.burst(2);
    ctrl.sync_disable = 1'b0;
    read_count(rd_val);
    check("mode switch", 16'(rd_val >= 16'h0005 && rd_val <= 16'h0007), 16'h0001);
    $display("test read and mode done");
    $display("test gate done");
    clear_flag();
    load(16'hfc00);
    u_far.burst(1023);
    check("flag early", 16'(flag), 16'h0000);
    u_far.burst(1);
    expect_count("rollover", 16'h0000);
    repeat (4) @(negedge clk_i);
    check("flag sticky", 16'(flag), 16'h0001);
    clear_flag();
    check("flag cleared", 16'(flag), 16'h0000);
    $display("test overflow done");
    load(16'hfff0);
    sleep = 1'b1;
    u_far.burst(2);
    expect_count("sync sleep hold", 16'hfff0);
    check("osc off", 16'(xoe), 16'h0000);
    ctrl.secondary_osc_enable = 1'b1;
    ctrl.sync_disable = 1'b1;
    ext_sel = 1'b1;
    repeat (200) @(negedge clk_i);
    #1;
    check("osc in sleep", 16'(xoe), 16'h0001);
    check("amp output", 16'(xout), 16'(!xin));
    check("async flag", 16'(flag), 16'h0001);
    check("wake", 16'(wake), 16'h0001);
    $display("test sleep done");
    @(negedge clk_i);
    reset_i = 1'b1;
    ctrl = '0;
    sleep = 1'b0;
    repeat (2) @(negedge clk_i);
    reset_i = 1'b0;
    expect_count("count after reset", 16'h0000);
    check("flag after reset", 16'(flag), 16'h0000);
    check("osc after reset", 16'(xoe), 16'h0000);
    $display("test reset again done");
    finish_test();
  end
endmodule
